// [dv/spi_host_model.sv]
// host-side serial master model that drives the command port
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input  wire logic clk,
  output logic      cs_n,
  output logic      sclk,
  output logic      din
);
  // half of the 160 ns serial period in 5 ns clk cycles
  localparam int half_cyc = 16;
  // deselected, serial clock parked low
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end
  // wait a number of falling clk edges
  task automatic pause(input int n);
    repeat (n) @(negedge clk);
  endtask
  // select the device
  task automatic open_frame();
    pause(1);
    cs_n = 1'b0;
    pause(half_cyc);
  endtask
  // msb first, data steady across rising sclk
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      din = b[i];
      pause(half_cyc);
      sclk = 1'b1;
      pause(half_cyc);
      sclk = 1'b0;
    end
  endtask
  // deselect; an undriven data line must not look like the last bit
  task automatic close_frame();
    pause(half_cyc);
    cs_n = 1'b1;
    din = ~din;
    pause(half_cyc);
  endtask
  // second byte only when two is set: then sixteen clocks under one select, as for a pair byte right after setup
  task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input bit two);
    open_frame();
    send_bits(b0, 8);
    if (two) begin
      send_bits(b1, 8);
    end
    close_frame();
  endtask
endmodule
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the command decoder and scan sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import adc_cmd_pkg::*;
  logic           clk, reset, cs_n, sclk, din, trig_n;      // stimulus
  logic [7:0]     conv_q, setup_q, avg_q, uni_q, bi_q;      // register views
  logic           fclr, req, s_diff, s_twos, s_temp, rv, busy;
  logic [3:0]     s_chan;
  scan_state_type st;
  int             fails, tests_run;
  // monitor totals and first result of the scan under test
  logic [15:0]    tot_req, tot_res, tot_busy, tot_clr, base_req;
  logic [3:0]     f_chan;
  logic           f_temp, f_diff, f_twos;
  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  adc_command_byte_decoder DUT (.clk(clk), .reset(reset), .cs_n(cs_n), .sclk(sclk),
    .din(din), .conv_trigger_pin_n(trig_n), .conversion_command(conv_q),
    .setup_config(setup_q), .averaging_config(avg_q), .unipolar_pair_flags(uni_q),
    .bipolar_pair_flags(bi_q), .fifo_clear(fclr), .sample_req(req), .sample_chan(s_chan),
    .sample_diff(s_diff), .sample_twos(s_twos), .sample_temp(s_temp),
    .result_valid(rv), .busy(busy), .scan_state(st));
  spi_host_model host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din));
  // count pulses and busy cycles; keep the first result's attributes
  always @(posedge clk) begin
    if (req === 1'b1) begin
      if (tot_req == base_req) begin
        f_chan <= s_chan;
        f_temp <= s_temp;
        f_diff <= s_diff;
        f_twos <= s_twos;
      end
      tot_req <= tot_req + 16'h0001;
    end
    if (rv === 1'b1) tot_res <= tot_res + 16'h0001;
    if (busy === 1'b1) tot_busy <= tot_busy + 16'h0001;
    if (fclr === 1'b1) tot_clr <= tot_clr + 16'h0001;
  end
  // compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic conclude();
    if (fails == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // start a scan by byte or by pin pulse, wait for its end, check results
  task automatic scan(input logic [7:0] cmd, input bit pin, input logic [15:0] n_res,
                      input logic [3:0] chan, input logic [2:0] tdt,
                      output logic [15:0] span);
    logic [15:0] b_res, b_busy;
    int k;
    b_res = tot_res;
    b_busy = tot_busy;
    base_req = tot_req;
    if (pin) begin
      trig_n = 1'b0;
      host.pause(4);
      trig_n = 1'b1;
    end else begin
      host.frame(cmd, 8'h00, 1'b0);
    end
    for (k = 0; k < 60000 && !(tot_busy != b_busy && busy === 1'b0); k++) begin
      @(negedge clk);
    end
    if (k == 60000) begin
      fails++;
      conclude();
    end
    span = tot_busy - b_busy;
    check("result count", tot_res - b_res, n_res);
    if (n_res != 16'h0000) begin
      check("first chan", {12'h000, f_chan}, {12'h000, chan});
      check("temp diff twos", {13'h0000, f_temp, f_diff, f_twos}, {13'h0000, tdt});
    end
  endtask
  logic [15:0] span, mark;                                   // scan length, count mark
  // main sequence
  initial begin
    {reset, trig_n} = 2'b11;
    {tot_req, tot_res, tot_busy, tot_clr, base_req} = '0;
    {f_chan, f_temp, f_diff, f_twos} = '0;
    fails = 0;
    tests_run = 0;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    host.pause(3);
    check("reset regs", {conv_q, avg_q}, 16'h0000);
    check("reset setup", {setup_q, uni_q | bi_q}, 16'h2000);
    host.frame(8'h6a, 8'h80, 1'b1);
    check("setup uni", {setup_q, uni_q}, 16'h6a80);
    host.frame(8'h6b, 8'hc0, 1'b1);
    check("bi uni", {bi_q, uni_q}, 16'hc080);
    host.frame(8'h68, 8'h34, 1'b1);
    check("fresh byte", {avg_q, uni_q}, 16'h3480);
    host.open_frame();
    host.send_bits(8'h2f, 5);
    host.close_frame();
    check("partial byte", {8'h00, avg_q}, 16'h0034);
    // eight samples per result with averaging on; channel 5 is single-ended,
    // channel 3 is the upper half of a flagged pair and would be skipped
    scan(8'hae, 1'b0, 16'h0001, 4'h5, 3'h0, span);
    check("avg span", {15'h0000, span >= 16'd4800}, 16'h0001);
    check("conv reg", {8'h00, conv_q}, 16'h00ae);
    host.frame(8'h2d, 8'h00, 1'b0);
    scan(8'hae, 1'b0, 16'h0001, 4'h5, 3'h0, span);
    check("plain span", {15'h0000, span < 16'd1000}, 16'h0001);
    scan(8'haf, 1'b0, 16'h0002, 4'h5, 3'h5, span);
    // pairs 0/1 flagged both ways, 2/3 bipolar; lower channel addresses a pair
    scan(8'h90, 1'b0, 16'h0002, 4'h0, 3'h2, span);
    scan(8'h92, 1'b0, 16'h000d, 4'h2, 3'h3, span);
    // repeat count code 01 gives eight results
    scan(8'hac, 1'b0, 16'h0008, 4'h5, 3'h0, span);
    // clock mode 00: the byte alone must not start a scan
    host.frame(8'h48, 8'h00, 1'b0);
    mark = tot_busy;
    host.frame(8'hfe, 8'h00, 1'b0);
    host.pause(40);
    check("no byte start", tot_busy, mark);
    // channel 15 is the start pin in this mode, so nothing is sampled
    scan(8'h00, 1'b1, 16'h0000, 4'h0, 3'h0, span);
    check("blocked reqs", tot_req, base_req);
    host.frame(8'hae, 8'h00, 1'b0);
    scan(8'h00, 1'b1, 16'h0001, 4'h5, 3'h0, span);
    // clock mode 01: pin fall starts the scan, pin rise ends the sample
    host.frame(8'h58, 8'h00, 1'b0);
    scan(8'h00, 1'b1, 16'h0001, 4'h5, 3'h0, span);
    check("pin timed span", {15'h0000, span < 16'h0020}, 16'h0001);
    host.frame(8'h18, 8'h00, 1'b0);
    check("fifo clear", tot_clr, 16'h0001);
    check("regs kept", {setup_q, avg_q}, 16'h582d);
    // clock mode 11: repeat sweep forced to once, the next byte paces it
    host.frame(8'h78, 8'h00, 1'b0);
    mark = tot_res;
    host.frame(8'hfc, 8'h00, 1'b1);
    check("serial results", tot_res - mark, 16'h0001);
    check("serial idle", {15'h0000, busy}, 16'h0000);
    host.frame(8'h10, 8'h00, 1'b0);
    check("soft reset", {setup_q, avg_q}, 16'h2000);
    check("soft reset pairs", {uni_q, bi_q}, 16'h0000);
    // default setup sleeps the internal reference, so the scan adds wake time
    scan(8'hae, 1'b0, 16'h0001, 4'h5, 3'h0, span);
    check("wake span", {15'h0000, span >= 16'h0a28}, 16'h0001);
    conclude();
  end
endmodule
`default_nettype wire

// [rtl/adc_cmd_defines.svh]
// constants for the converter command decoder and scan sequencer
`ifndef ADC_CMD_DEFINES_SVH
`define ADC_CMD_DEFINES_SVH
// clock and scan timing, times in ns
`define CLK_PERIOD_NS   5
`define T_SAMPLE_NS     3000
`define T_TEMP_NS       20000
`define T_WAKE_NS       10000
`define CYC_OF(t)       ((t + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SAMPLE_CYC      12'(`CYC_OF(`T_SAMPLE_NS))
`define TEMP_CYC        12'(`CYC_OF(`T_TEMP_NS))
`define WAKE_CYC        12'(`CYC_OF(`T_WAKE_NS))
// field positions
`define BIT_TEMP        0
`define BIT_RST         3
`define BIT_AVG_ON      4
`define BIT_CLK_HI      5
`define F_CHAN          6:3
`define F_SWEEP         2:1
`define F_CLK_MODE      5:4
`define F_VREF_MODE     3:2
`define F_PAIR_SEL      1:0
`define F_SAMPLE_CNT    3:2
`define F_REPEAT_CNT    1:0
// reset values
`define SETUP_RESET     8'h20
`define REG_RESET       8'h00
// codes
`define SWEEP_UP_TO_N   2'h0
`define SWEEP_N_UP      2'h1
`define SWEEP_REPEAT    2'h2
`define SWEEP_ONCE      2'h3
`define CLK_SERIAL      2'h3
`define CLK_TRIG_ACQ    2'h1
`define VREF_INT_SLEEP  2'h0
`define VREF_EXT_DIFF   2'h3
`define PAIR_SEL_UNI    2'h2
`define PAIR_SEL_BI     2'h3
// channel facts
`define CHAN_TOP        4'hf
`define TRIG_CHAN       4'hf
`define REFN_CHAN       4'he
`define LAST_BIT        3'h7
`define SAMPLE_BASE     6'h01
`define SAMPLE_SHIFT    6'h04
// repeat sweep gives four results per count step
`define REPS_STEP       5'h04
`endif

// [rtl/adc_cmd_pkg.sv]
// types shared by the converter command decoder
package adc_cmd_pkg;
  // target of a decoded command byte
  typedef enum logic [2:0] {
    kind_none  = 3'h0,
    kind_conv  = 3'h1,
    kind_setup = 3'h2,
    kind_avg   = 3'h3,
    kind_rst   = 3'h4
  } cmd_kind_type;
  // scan sequencer states
  typedef enum logic [2:0] {
    sc_idle = 3'h0,
    sc_wake = 3'h1,
    sc_temp = 3'h2,
    sc_pick = 3'h3,
    sc_conv = 3'h4
  } scan_state_type;
endpackage

// [rtl/adc_command_byte_decoder.sv]
// serial command decoder, configuration registers and scan sequencer
`timescale 1ns/1ps
`include "adc_cmd_defines.svh"
`default_nettype none
module adc_command_byte_decoder (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    cs_n,              // chip select pin
  input  wire logic                    sclk,              // serial clock pin
  input  wire logic                    din,               // serial data pin
  input  wire logic                    conv_trigger_pin_n,// start pin, low pulse
  output logic [7:0]                   conversion_command,
  output logic [7:0]                   setup_config,
  output logic [7:0]                   averaging_config,
  output logic [7:0]                   unipolar_pair_flags,
  output logic [7:0]                   bipolar_pair_flags,
  output logic                         fifo_clear,        // one-cycle pulse
  output logic                         sample_req,        // one-cycle pulse
  output logic [3:0]                   sample_chan,
  output logic                         sample_diff,
  output logic                         sample_twos,
  output logic                         sample_temp,
  output logic                         result_valid,      // one-cycle pulse
  output logic                         busy,
  output adc_cmd_pkg::scan_state_type  scan_state
);
  import adc_cmd_pkg::*;

  // leading-bit priority decode of a byte
  function automatic cmd_kind_type decode_kind(input logic [7:0] b);
    decode_kind = b[7] ? kind_conv : b[6] ? kind_setup : b[5] ? kind_avg :
                  b[4] ? kind_rst : kind_none;
  endfunction
  // channel taken over by trigger pin or negative reference
  function automatic logic chan_blocked(input logic [3:0] ch, input logic [7:0] su);
    chan_blocked = ((ch == `TRIG_CHAN) && !su[`BIT_CLK_HI]) ||
                   ((ch == `REFN_CHAN) && (su[`F_VREF_MODE] == `VREF_EXT_DIFF));
  endfunction
  // pin synchronisers, first stage feeds only the second
  logic cs_meta_r, cs_s_r, sclk_meta_r, sclk_s_r, sclk_d_r;
  logic din_meta_r, din_s_r, trig_meta_r, trig_s_r, trig_d_r;
  // serial receiver
  logic [7:0] shift_r;          // bits received so far
  logic [2:0] bit_cnt_r;        // bit index within byte
  logic       pair_pend_r;      // next byte goes to a pair register
  logic       pair_bi_r;        // that register is the bipolar one
  logic       conv_seen_r;      // a conversion byte has been written
  // scan sequencer
  scan_state_type st_r;
  logic [4:0] cur_ch_r;         // channel under consideration
  logic [3:0] last_ch_r;        // last channel of the range
  logic [1:0] sweep_r;          // latched sweep code
  logic [1:0] ck_r;             // latched clock mode
  logic       temp_pend_r;      // temperature still owed
  logic [4:0] reps_r;           // results left on repeat sweep
  logic [5:0] navg_r;           // samples per result
  logic [5:0] samp_left_r;      // samples left in result
  logic [11:0] timer_r;         // internal timing count
  // sampled pins
  always_ff @(posedge clk) begin
    cs_meta_r   <= cs_n;
    cs_s_r      <= cs_meta_r;
    sclk_meta_r <= sclk;
    sclk_s_r    <= sclk_meta_r;
    sclk_d_r    <= sclk_s_r;
    din_meta_r  <= din;
    din_s_r     <= din_meta_r;
    trig_meta_r <= conv_trigger_pin_n;
    trig_s_r    <= trig_meta_r;
    trig_d_r    <= trig_s_r;
  end
  // edge and byte decode
  wire        sclk_rise  = sclk_s_r && !sclk_d_r && !cs_s_r;
  wire        trig_fall  = !trig_s_r && trig_d_r;
  wire        trig_rise  = trig_s_r && !trig_d_r;
  wire [7:0]  shift_nxt  = {shift_r[6:0], din_s_r};
  // eighth rising edge completes the byte
  wire        byte_done  = sclk_rise && (bit_cnt_r == `LAST_BIT);
  wire        cmd_done   = byte_done && !pair_pend_r;
  cmd_kind_type kind;
  assign kind = decode_kind(shift_nxt);
  wire        wr_conv    = cmd_done && (kind == kind_conv);
  wire        wr_setup   = cmd_done && (kind == kind_setup);
  wire        wr_avg     = cmd_done && (kind == kind_avg);
  wire        wr_rst     = cmd_done && (kind == kind_rst);
  // reset bit picks fifo clear or full reset
  wire        soft_rst   = wr_rst && !shift_nxt[`BIT_RST];
  wire        clr_fifo   = wr_rst && shift_nxt[`BIT_RST];
  // serial receiver: shift, count, pair routing
  always_ff @(posedge clk) begin
    if (reset || cs_s_r) begin
      // chip select high drops any partial byte
      bit_cnt_r   <= 3'h0;
      pair_pend_r <= 1'b0;
      pair_bi_r   <= 1'b0;
      shift_r     <= 8'h00;
    end else if (sclk_rise) begin
      shift_r   <= shift_nxt;
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (byte_done) begin
        // pair select 1x arms the next byte
        pair_pend_r <= wr_setup && shift_nxt[1];
        pair_bi_r   <= shift_nxt[0];
      end
    end
  end
  // configuration registers
  always_ff @(posedge clk) begin
    if (reset || soft_rst) begin
      conversion_command  <= `REG_RESET;
      setup_config        <= `SETUP_RESET;
      averaging_config    <= `REG_RESET;
      unipolar_pair_flags <= `REG_RESET;
      bipolar_pair_flags  <= `REG_RESET;
      conv_seen_r         <= 1'b0;
    end else begin
      if (wr_conv) begin
        conversion_command <= shift_nxt;
        conv_seen_r        <= 1'b1;
      end
      if (wr_setup) begin
        setup_config <= shift_nxt;
      end
      if (wr_avg) begin
        averaging_config <= shift_nxt;
      end
      // only an armed byte reaches a pair register
      if (byte_done && pair_pend_r && !pair_bi_r) begin
        unipolar_pair_flags <= shift_nxt;
      end
      if (byte_done && pair_pend_r && pair_bi_r) begin
        bipolar_pair_flags <= shift_nxt;
      end
    end
  end
  // scan start decode
  wire [1:0] ck_mode    = setup_config[`F_CLK_MODE];
  // command starts modes 1x, trigger pulse modes 0x
  wire       start_cmd  = wr_conv && ck_mode[1];
  wire       start_trig = trig_fall && !ck_mode[1] && conv_seen_r;
  wire       start_scan = (st_r == sc_idle) && !soft_rst && (start_cmd || start_trig);
  wire [7:0] cmd_now    = wr_conv ? shift_nxt : conversion_command;
  // serial clock mode forces a single conversion
  wire [1:0] sweep_now  = (ck_mode == `CLK_SERIAL) ? `SWEEP_ONCE : cmd_now[`F_SWEEP];
  wire [3:0] n_now      = cmd_now[`F_CHAN];
  // averaging only when enabled and not serially clocked
  wire       avg_en     = averaging_config[`BIT_AVG_ON] && (ck_mode != `CLK_SERIAL);
  // 4, 8, 16 or 32 samples per result
  wire [5:0] navg_now   = avg_en ? (`SAMPLE_SHIFT << averaging_config[`F_SAMPLE_CNT])
                                 : `SAMPLE_BASE;
  // repeat count 4, 8, 12 or 16 results
  wire [4:0] reps_now   = (sweep_now == `SWEEP_REPEAT)
                          ? {1'b0, averaging_config[`F_REPEAT_CNT], 2'h0} + `REPS_STEP
                          : 5'h01;
  // up to n, n upward, or n alone
  wire [4:0] first_now  = (sweep_now == `SWEEP_UP_TO_N) ? 5'h00 : {1'b0, n_now};
  wire [3:0] last_now   = (sweep_now == `SWEEP_N_UP) ? `CHAN_TOP : n_now;
  // candidate channel examination
  wire [3:0] cur4       = cur_ch_r[3:0];
  wire [2:0] pair_idx   = cur4[3:1];
  wire       uni_flag   = unipolar_pair_flags[3'h7 - pair_idx];
  wire       bi_flag    = bipolar_pair_flags[3'h7 - pair_idx];
  wire       is_diff    = uni_flag || bi_flag;
  // a pair is addressed from its lower channel, blocked if either member is
  wire       pair_block = chan_blocked({pair_idx, 1'b0}, setup_config) ||
                          chan_blocked({pair_idx, 1'b1}, setup_config);
  wire       skip_ch    = is_diff ? (cur4[0] || pair_block)
                                  : chan_blocked(cur4, setup_config);
  wire       past_end   = cur_ch_r > {1'b0, last_ch_r};
  wire [4:0] step       = (is_diff && !cur4[0]) ? 5'h02 : 5'h01;
  wire       tick_int   = (timer_r == 12'h000);
  wire       sample_end = (ck_r == `CLK_SERIAL)   ? byte_done :
                          (ck_r == `CLK_TRIG_ACQ) ? trig_rise : tick_int;

  // scan sequencer
  always_ff @(posedge clk) begin
    sample_req   <= 1'b0;
    result_valid <= 1'b0;
    fifo_clear   <= clr_fifo && !reset;
    if (reset || soft_rst) begin
      st_r        <= sc_idle;
      cur_ch_r    <= 5'h00;
      last_ch_r   <= 4'h0;
      sweep_r     <= `SWEEP_ONCE;
      ck_r        <= 2'h0;
      temp_pend_r <= 1'b0;
      reps_r      <= 5'h00;
      navg_r      <= `SAMPLE_BASE;
      samp_left_r <= 6'h00;
      timer_r     <= 12'h000;
      sample_chan <= 4'h0;
      sample_diff <= 1'b0;
      sample_twos <= 1'b0;
      sample_temp <= 1'b0;
      busy        <= 1'b0;
    end else begin
      if (timer_r != 12'h000) begin
        timer_r <= timer_r - 12'h001;
      end
      unique case (st_r)
        sc_idle: begin
          if (start_scan) begin
            cur_ch_r    <= first_now;
            last_ch_r   <= last_now;
            sweep_r     <= sweep_now;
            ck_r        <= ck_mode;
            temp_pend_r <= cmd_now[`BIT_TEMP];
            reps_r      <= reps_now;
            navg_r      <= navg_now;
            busy        <= 1'b1;
            // wake time only for the sleeping internal reference
            if (setup_config[`F_VREF_MODE] == `VREF_INT_SLEEP) begin
              timer_r <= `WAKE_CYC;
              st_r    <= sc_wake;
            end else begin
              st_r <= sc_pick;
            end
          end
        end
        sc_wake: begin
          if (tick_int) begin
            st_r <= sc_pick;
          end
        end
        sc_temp: begin
          // temperature time counted only when asked for
          if (tick_int) begin
            result_valid <= 1'b1;
            st_r         <= sc_pick;
          end
        end
        sc_pick: begin
          if (temp_pend_r) begin
            temp_pend_r <= 1'b0;
            sample_req  <= 1'b1;
            sample_temp <= 1'b1;
            sample_twos <= 1'b1;
            sample_diff <= 1'b0;
            timer_r     <= `TEMP_CYC;
            st_r        <= sc_temp;
          end else if (past_end) begin
            busy <= 1'b0;
            st_r <= sc_idle;
          end else if (skip_ch) begin
            cur_ch_r <= cur_ch_r + 5'h01;
          end else begin
            // one result per input or pair in range, reps_r results for the channel on repeat sweep
            sample_req  <= 1'b1;
            sample_temp <= 1'b0;
            sample_chan <= cur4;
            sample_diff <= is_diff;
            // unipolar wins when both flags set
            // bipolar pairs come out in twos complement
            sample_twos <= bi_flag && !uni_flag;
            samp_left_r <= navg_r;
            timer_r     <= `SAMPLE_CYC;
            st_r        <= sc_conv;
          end
        end
        sc_conv: begin
          // serial mode advances on each completed byte
          if (sample_end) begin
            if (samp_left_r > 6'h01) begin
              samp_left_r <= samp_left_r - 6'h01;
              timer_r     <= `SAMPLE_CYC;
            end else begin
              result_valid <= 1'b1;
              st_r         <= sc_pick;
              if (reps_r > 5'h01) begin
                reps_r <= reps_r - 5'h01;
              end else if (sweep_r == `SWEEP_UP_TO_N || sweep_r == `SWEEP_N_UP) begin
                cur_ch_r <= cur_ch_r + step;
              end else begin
                cur_ch_r <= {1'b0, last_ch_r} + 5'h01;
              end
            end
          end
        end
        default: begin
          st_r <= sc_idle;
        end
      endcase
    end
  end

  assign scan_state = st_r;

  // conversion byte lands in its register
  a_conv_route: assert property (@(posedge clk) disable iff (reset)
    wr_conv |=> conversion_command == $past(shift_nxt))
    else $error("conversion byte not stored");
  // setup byte never reaches averaging register
  a_setup_route: assert property (@(posedge clk) disable iff (reset)
    wr_setup |=> setup_config == $past(shift_nxt) && $stable(averaging_config))
    else $error("setup byte misrouted");
  // armed byte with pair_bi_r clear written to unipolar register, bipolar one kept
  a_pair_uni: assert property (@(posedge clk) disable iff (reset)
    (byte_done && pair_pend_r && !pair_bi_r) |=>
      unipolar_pair_flags == $past(shift_nxt) && $stable(bipolar_pair_flags))
    else $error("pair byte misrouted");
  // chip select high clears the bit count
  a_partial_drop: assert property (@(posedge clk) disable iff (reset)
    cs_s_r |=> bit_cnt_r == 3'h0 && !pair_pend_r)
    else $error("partial byte kept");
  a_soft_reset: assert property (@(posedge clk) disable iff (reset)
    soft_rst |=> setup_config == `SETUP_RESET && averaging_config == `REG_RESET
                 && st_r == sc_idle)
    else $error("reset byte did not restore defaults");
  // fifo clear pulse follows the byte
  a_fifo_clear: assert property (@(posedge clk) disable iff (reset)
    clr_fifo |=> fifo_clear ##1 !fifo_clear)
    else $error("fifo clear pulse wrong");
  // no channel sample while temperature owed
  a_temp_first: assert property (@(posedge clk) disable iff (reset)
    (sample_req && !sample_temp) |-> !temp_pend_r)
    else $error("channel sampled before temperature");
  a_block_skip: assert property (@(posedge clk) disable iff (reset)
    (sample_req && !sample_temp && !sample_diff) |->
      !chan_blocked(sample_chan, setup_config))
    else $error("blocked channel sampled");
  a_uni_wins: assert property (@(posedge clk) disable iff (reset)
    (sample_req && sample_diff &&
     unipolar_pair_flags[3'h7 - sample_chan[3:1]]) |-> !sample_twos)
    else $error("unipolar precedence broken");
  // start makes the sequencer busy next cycle
  a_start_busy: assert property (@(posedge clk) disable iff (reset)
    start_scan |=> busy ##1 busy)
    else $error("scan did not start");
endmodule
`default_nettype wire
